// ---- hw/smc_motor_ctrl.sv ----
/*
 * Spindle start/regulation sequencer and actuator servo sequencer.
 * Assumes the speed pulse, servo mark and sample tick are one-cycle
 * pulses synchronous to i_sys_clk; the spindle driver commutates
 * by itself and the coil amplifier follows the written current.
 */
module smc_motor_ctrl
  import smc_pkg::*;
#(
  parameter int CNT_W           = 24,
  parameter int CHARGE_WAIT     = smc_pkg::CHARGE_WAIT_CYC,
  parameter int PULSE_TIMEOUT   = smc_pkg::PULSE_TMO_CYC,
  parameter int REF_REV         = smc_pkg::REF_REV_CYC,
  parameter int K_NUM           = smc_pkg::K_CORR
) (
  // clock and reset
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_rst,
  // spindle driver
  input  wire logic                     i_speed_pulse,
  output logic                          o_spindle_reset,
  output logic                          o_spindle_charge,
  output logic                          o_spindle_discharge,
  output logic                          o_spindle_start,
  output logic                          o_spindle_commutate,
  output logic                          o_spindle_stable,
  // servo frame
  input  wire logic                     i_sample_tick,
  input  wire logic                     i_servo_mark,
  input  wire logic                     i_gray_valid,
  input  wire logic [smc_pkg::CYL_W-1:0] i_gray_cyl,
  input  wire logic                     i_gray_index,
  input  wire logic signed [15:0]       i_burst_a,
  input  wire logic signed [15:0]       i_burst_b,
  // seek request
  input  wire logic                     i_seek_req,
  input  wire logic [smc_pkg::CYL_W-1:0] i_seek_target,
  output logic                          o_seek_busy,
  // actuator coil converter
  output logic                          o_coil_wr,
  output logic signed [smc_pkg::COIL_W-1:0] o_coil_current,
  output logic [smc_pkg::CYL_W-1:0]     o_cyl_addr,
  output logic                          o_cyl_index,
  output logic                          o_tracking
);

  localparam int RW = CNT_W + 3;
  localparam int PW = RW + 8;

  // ****************************************************************
  // spindle sequencing
  // ****************************************************************
  smc_spin_e        spin_reg;
  logic [CNT_W-1:0] wait_reg;
  logic [CNT_W-1:0] ivl_reg;
  logic [RW-1:0]    corr_reg;
  logic             corr_up_reg;
  logic [RW-1:0]    rev_est;
  logic [RW-1:0]    ref_rev;
  logic [RW-1:0]    diff;
  logic [PW-1:0]    corr_prod;
  logic             fast;

  // six pulses per turn: one interval times six is one revolution
  assign rev_est   = ({3'h0, ivl_reg} << 2) + ({3'h0, ivl_reg} << 1);
  assign ref_rev   = RW'(REF_REV);
  assign fast      = rev_est < ref_rev;
  assign diff      = fast ? ref_rev - rev_est : rev_est - ref_rev;
  assign corr_prod = ({8'h00, diff} * PW'(K_NUM)) >> K_SHIFT;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      spin_reg <= SP_RESET;
      wait_reg <= '0;
    end else begin
      unique case (spin_reg)
        SP_RESET: begin
          spin_reg <= SP_CHARGE;
          wait_reg <= '0;
        end
        SP_CHARGE: begin
          wait_reg <= wait_reg + 1'b1;
          if (wait_reg >= CNT_W'(CHARGE_WAIT - 1)) begin
            spin_reg <= SP_START;
            wait_reg <= '0;
          end
        end
        SP_START: begin
          wait_reg <= wait_reg + 1'b1;
          if (i_speed_pulse) begin
            spin_reg <= SP_ACCEL;
          end else if (wait_reg >= CNT_W'(PULSE_TIMEOUT - 1)) begin
            spin_reg <= SP_RESET;
          end
        end
        SP_ACCEL: begin
          // first pulse only restarts the interval measurement
          if (i_speed_pulse && ivl_reg != '0 && !(rev_est > ref_rev)) begin
            spin_reg <= SP_STABLE;
          end
        end
        SP_STABLE: begin
          spin_reg <= SP_STABLE;
        end
      endcase
    end
  end

  // interval between speed pulses, saturating
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || spin_reg == SP_START) begin
      ivl_reg <= '0;
    end else if (i_speed_pulse) begin
      ivl_reg <= CNT_W'(1);
    end else if (ivl_reg != '1 && ivl_reg != '0) begin
      ivl_reg <= ivl_reg + 1'b1;
    end
  end

  // correction is reloaded on every pulse, i.e. each 1/6 turn
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || spin_reg != SP_STABLE) begin
      corr_reg    <= '0;
      corr_up_reg <= 1'b0;
    end else if (i_speed_pulse && ivl_reg != '0) begin
      corr_reg    <= corr_prod[RW-1:0];
      corr_up_reg <= !fast;
    end else if (corr_reg != '0) begin
      corr_reg <= corr_reg - 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_spindle_reset     <= 1'b0;
      o_spindle_charge    <= 1'b0;
      o_spindle_discharge <= 1'b0;
      o_spindle_start     <= 1'b0;
      o_spindle_commutate <= 1'b0;
      o_spindle_stable    <= 1'b0;
    end else begin
      o_spindle_reset     <= spin_reg == SP_RESET;
      // charging in accel keeps the motor current rising
      o_spindle_charge    <= spin_reg == SP_CHARGE
                          || spin_reg == SP_ACCEL
                          || (spin_reg == SP_STABLE && corr_reg != '0
                              && corr_up_reg);
      o_spindle_discharge <= spin_reg == SP_STABLE && corr_reg != '0
                          && !corr_up_reg;
      o_spindle_start     <= spin_reg == SP_START;
      o_spindle_commutate <= spin_reg == SP_START;
      o_spindle_stable    <= spin_reg == SP_STABLE;
    end
  end

  // ****************************************************************
  // cylinder address
  // ****************************************************************
  logic             cyl_valid;

  smc_gray_decode #(
    .W (CYL_W)
  ) u_gray (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_valid   (i_gray_valid),
    .i_gray    (i_gray_cyl),
    .i_index   (i_gray_index),
    .o_valid   (cyl_valid),
    .o_bin     (o_cyl_addr),
    .o_index   (o_cyl_index)
  );

  // ****************************************************************
  // actuator sequencing, one step per sample tick
  // ****************************************************************
  smc_act_e                  act_reg;
  logic [7:0]                press_reg;
  logic [CYL_W-1:0]          target_reg;
  logic signed [19:0]        integ_reg;
  logic signed [16:0]        pos_err;
  logic signed [CYL_W:0]     seek_err;
  logic signed [23:0]        seek_cur;
  logic signed [23:0]        trk_cur;

  assign pos_err  = 17'(i_burst_a) - 17'(i_burst_b);
  assign seek_err = $signed({1'b0, target_reg}) - $signed({1'b0, o_cyl_addr});
  assign seek_cur = 24'(seek_err) <<< SEEK_SHIFT;
  // proportional plus integral compensation
  assign trk_cur  = -(24'(pos_err) <<< 1)
                  - (24'(integ_reg) >>> TRK_I_SHIFT);

  function automatic logic signed [COIL_W-1:0] sat(
    input logic signed [23:0] v
  );
    if (v > 24'sh007FFF) begin
      sat = 16'sh7FFF;
    end else if (v < -24'sh008000) begin
      sat = -16'sh8000;
    end else begin
      sat = v[COIL_W-1:0];
    end
  endfunction : sat

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      act_reg    <= ACT_PRESS;
      press_reg  <= '0;
      target_reg <= '0;
    end else if (i_sample_tick) begin
      unique case (act_reg)
        ACT_PRESS: begin
          press_reg <= press_reg + 1'b1;
          if (press_reg == 8'(PRESS_SAMPLES - 1)) begin
            act_reg <= ACT_OUT;
          end
        end
        ACT_OUT: begin
          if (i_servo_mark) begin
            act_reg <= ACT_SLOW;
          end
        end
        ACT_SLOW: begin
          if (cyl_valid && o_cyl_addr <= CYL_W'(REF_CYL)) begin
            act_reg <= ACT_TRACK;
          end
        end
        ACT_TRACK: begin
          // seeks only start once the spindle is at speed
          if (i_seek_req && o_spindle_stable) begin
            act_reg    <= ACT_SEEK;
            target_reg <= i_seek_target;
          end
        end
        ACT_SEEK: begin
          if (seek_err == '0) begin
            act_reg <= ACT_TRACK;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst || act_reg != ACT_TRACK) begin
      integ_reg <= '0;
    end else if (i_sample_tick) begin
      integ_reg <= integ_reg + 20'(pos_err);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_coil_wr      <= 1'b0;
      o_coil_current <= '0;
    end else begin
      o_coil_wr <= i_sample_tick;
      if (i_sample_tick) begin
        unique case (act_reg)
          ACT_PRESS: o_coil_current <= PRESS_CUR;
          ACT_OUT:   o_coil_current <= OUT_CUR;
          ACT_SLOW:  o_coil_current <= SLOW_CUR;
          ACT_TRACK: o_coil_current <= sat(trk_cur);
          ACT_SEEK:  o_coil_current <= sat(seek_cur);
        endcase
      end
    end
  end

  assign o_seek_busy = act_reg == ACT_SEEK;
  assign o_tracking  = act_reg == ACT_TRACK;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  a_charge_first: assert property (
    $rose(o_spindle_start) |-> $past(o_spindle_charge, 2))
    else $error("start without prior charging");
  a_start_after_charge: assert property (
    spin_reg == SP_CHARGE ##1 spin_reg == SP_START
    |=> o_spindle_start && !o_spindle_charge)
    else $error("start mode not driven after charge");
  a_timeout_restart: assert property (
    spin_reg == SP_RESET |=> spin_reg == SP_CHARGE && o_spindle_reset)
    else $error("driver reset not followed by charging");
  a_pulse_to_accel: assert property (
    spin_reg == SP_START && i_speed_pulse |=> spin_reg == SP_ACCEL)
    else $error("speed pulse in start did not enter accel");
  a_no_commutate: assert property (
    spin_reg == SP_ACCEL ##1 spin_reg == SP_ACCEL |-> !o_spindle_commutate)
    else $error("commutation driven during accel");
  a_accel_stable: assert property (
    spin_reg == SP_ACCEL && i_speed_pulse && ivl_reg != '0
    && rev_est <= ref_rev |=> spin_reg == SP_STABLE ##1 o_spindle_stable)
    else $error("speed reached but not stable");
  a_corr_dir: assert property (
    spin_reg == SP_STABLE && i_speed_pulse && ivl_reg != '0 && fast
    && corr_prod != '0 |=> ##1 o_spindle_discharge && !o_spindle_charge)
    else $error("fast spindle not discharged");
  a_coil_sample: assert property (
    $changed(o_coil_current) |-> $past(i_sample_tick) && o_coil_wr)
    else $error("coil current changed off a sample");
  a_seek_arrive: assert property (
    act_reg == ACT_SEEK && i_sample_tick && seek_err == '0
    |=> o_tracking)
    else $error("seek arrival did not resume tracking");
  a_gray_decode: assert property (
    i_gray_valid |=> o_cyl_addr == ($past(i_gray_cyl)
      ^ (o_cyl_addr >> 1)))
    else $error("gray decode mismatch");

  c_restart:  cover property (o_spindle_reset ##[1:8] o_spindle_charge);
  c_stable:   cover property ($rose(o_spindle_stable));
  c_seek:     cover property ($rose(o_seek_busy) ##[1:1000] $rose(o_tracking));
  c_disch:    cover property ($rose(o_spindle_discharge));

endmodule : smc_motor_ctrl

// ---- hw/smc_pkg.sv ----
/*
 * Shared constants for the spindle and actuator motor sequencer.
 * Assumes a single 25 MHz system clock and a synchronous reset.
 */
package smc_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int CLK_MHZ        = 25;
  // reference revolution time at 5,400 rpm, 11.111 ms, in microseconds
  localparam int REF_REV_US     = 11111;
  localparam int REF_REV_CYC    = REF_REV_US * CLK_MHZ;
  // charge-sufficient wait, 1 ms by default
  localparam int CHARGE_WAIT_US = 1000;
  localparam int CHARGE_WAIT_CYC = CHARGE_WAIT_US * CLK_MHZ;
  // start-mode speed pulse timeout, 100 ms by default
  localparam int PULSE_TMO_US   = 100000;
  localparam int PULSE_TMO_CYC  = PULSE_TMO_US * CLK_MHZ;
  // speed pulses per revolution: one correction each 1/6 turn
  localparam int PULSES_PER_REV = 6;

  // ****************************************************************
  // correction constant k, fixed point with K_SHIFT fraction bits
  // ****************************************************************
  localparam int K_CORR  = 16;
  localparam int K_SHIFT = 4;

  // ****************************************************************
  // actuator currents and gains
  // ****************************************************************
  localparam int COIL_W        = 16;
  localparam int CYL_W         = 15;
  localparam int REF_CYL       = 0;
  localparam int PRESS_SAMPLES = 64;
  localparam logic signed [15:0] PRESS_CUR = 16'sh0040;
  localparam logic signed [15:0] OUT_CUR   = -16'sh0400;
  localparam logic signed [15:0] SLOW_CUR  = -16'sh0080;
  localparam int SEEK_SHIFT    = 2;
  localparam int TRK_I_SHIFT   = 3;

  typedef enum logic [2:0] {
    SP_RESET, SP_CHARGE, SP_START, SP_ACCEL, SP_STABLE
  } smc_spin_e;

  typedef enum logic [2:0] {
    ACT_PRESS, ACT_OUT, ACT_SLOW, ACT_TRACK, ACT_SEEK
  } smc_act_e;

endpackage : smc_pkg

// ---- hw/smc_gray_decode.sv ----
/*
 * Gray to binary conversion of the servo cylinder address field.
 * Assumes the gray field and its index bit are stable while valid.
 */
module smc_gray_decode #(
  parameter int W = 15
) (
  // clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst,
  // gray field in
  input  wire logic         i_valid,
  input  wire logic [W-1:0] i_gray,
  input  wire logic         i_index,
  // binary address out
  output logic              o_valid,
  output logic [W-1:0]      o_bin,
  output logic              o_index
);

  logic [W-1:0] bin_next;

  // ****************************************************************
  // each binary bit is the parity of the gray bits at and above it
  // ****************************************************************
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign bin_next[i] = ^i_gray[W-1:i];
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_bin   <= '0;
      o_index <= 1'b0;
    end else begin
      o_valid <= i_valid;
      if (i_valid) begin
        o_bin   <= bin_next;
        o_index <= i_index;
      end
    end
  end

endmodule : smc_gray_decode

// ---- verification/smc_drv_model.sv ----
/*
 * Far-side model: spindle driver speed pulses and coil amplifier.
 * Assumes the bench sets the pulse interval; 0 keeps the motor still.
 */
module smc_drv_model (
  // clock and reset
  input  wire logic               i_sys_clk,
  input  wire logic               i_rst,
  // spindle driver
  input  wire logic               i_spindle_reset,
  input  wire logic               i_spindle_start,
  input  wire logic [15:0]        i_ivl,
  output logic                    o_speed_pulse,
  output logic [2:0]              o_phase,
  // coil amplifier
  input  wire logic               i_coil_wr,
  input  wire logic signed [15:0] i_coil_current,
  output logic signed [15:0]      o_coil_level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] cnt_reg;
  logic [2:0]  step_reg;
  // ****************************************************************
  // self commutation, six steps 0 to 5, each taken once per cycle
  // ****************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || i_spindle_reset || !i_spindle_start) begin
      step_reg <= 3'h0;
    end else begin
      step_reg <= (step_reg == 3'h5) ? 3'h0 : step_reg + 3'h1;
    end
  end
  assign o_phase = step_reg;
  // ****************************************************************
  // back emf speed pulses
  // ****************************************************************
  // >= so a shortened interval never wraps the counter
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || i_spindle_reset || i_ivl == 16'h0) begin
      cnt_reg       <= 16'h0;
      o_speed_pulse <= 1'b0;
    end else begin
      o_speed_pulse <= (cnt_reg >= i_ivl - 16'h1);
      cnt_reg <= (cnt_reg >= i_ivl - 16'h1) ? 16'h0 : cnt_reg + 16'h1;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_coil_level <= 16'sh0;
    end else if (i_coil_wr) begin
      o_coil_level <= i_coil_current;
    end
  end
endmodule : smc_drv_model

// ---- verification/smc_motor_ctrl_tb.sv ----
/*
 * Self-checking bench for the motor sequencer with short counts.
 * Assumes the far-side model answers the spindle and coil ports.
 */
module smc_motor_ctrl_tb;
  import smc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CW = 20;
  localparam int PT = 200;
  localparam int RR = 600;
  logic clk = 1'b0;
  logic rst, pulse, sreset, chg, dis, start, comm, stable, tick, mark;
  logic gv, gidx, sreq, busy, cwr, cidx, trk;
  logic [14:0] gcyl, tgt, cyl;
  logic signed [15:0] ba, bb, cur;
  logic [15:0] ivl;
  int n_fail = 0;
  int n_compared = 0;
  int i, j, dc, cc;
  always #20 clk = ~clk;
  smc_motor_ctrl #(.CHARGE_WAIT(CW), .PULSE_TIMEOUT(PT), .REF_REV(RR))
  dut (.i_sys_clk(clk), .i_rst(rst), .i_speed_pulse(pulse),
    .o_spindle_reset(sreset), .o_spindle_charge(chg),
    .o_spindle_discharge(dis), .o_spindle_start(start),
    .o_spindle_commutate(comm), .o_spindle_stable(stable),
    .i_sample_tick(tick), .i_servo_mark(mark), .i_gray_valid(gv),
    .i_gray_cyl(gcyl), .i_gray_index(gidx), .i_burst_a(ba),
    .i_burst_b(bb), .i_seek_req(sreq), .i_seek_target(tgt),
    .o_seek_busy(busy), .o_coil_wr(cwr), .o_coil_current(cur),
    .o_cyl_addr(cyl), .o_cyl_index(cidx), .o_tracking(trk));
  smc_drv_model drv (.i_sys_clk(clk), .i_rst(rst),
    .i_spindle_reset(sreset), .i_spindle_start(start), .i_ivl(ivl),
    .o_speed_pulse(pulse), .o_phase(), .i_coil_wr(cwr),
    .i_coil_current(cur), .o_coil_level());
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      n_fail++;
    end
  endtask : check
  task automatic give_verdict;
    $display("compared=%0d mismatches=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict
  task automatic tmo;
    n_fail++;
    give_verdict();
  endtask : tmo
  // one sample tick, optional servo mark and seek request with it
  task automatic do_tick(input logic chk, input logic [15:0] exp,
                         input logic mk, input logic sk);
    @(posedge clk);
    tick <= 1'b1;
    gv   <= 1'b0;
    mark <= mk;
    sreq <= sk;
    @(posedge clk);
    tick <= 1'b0;
    mark <= 1'b0;
    sreq <= 1'b0;
    for (i = 0; i < 4 && cwr !== 1'b1; i++) @(negedge clk);
    if (cwr !== 1'b1) tmo();
    if (chk) check(cur, exp);
  endtask : do_tick
  task automatic put_gray(input logic [14:0] b, input logic x);
    @(posedge clk);
    gv   <= 1'b1;
    gcyl <= b ^ (b >> 1);
    gidx <= x;
    @(posedge clk);
    gv <= 1'b0;
    @(negedge clk);
    check({x, cyl}, {x, b});
    check(cidx, x);
  endtask : put_gray
  task automatic wpulse;
    for (i = 0; i < 400 && pulse !== 1'b1; i++) @(negedge clk);
    if (pulse !== 1'b1) tmo();
    @(negedge clk);
  endtask : wpulse
  // one interval of correction after a settled pulse train
  task automatic meas(input logic [15:0] v, input int ed, input int ec);
    @(posedge clk);
    ivl <= v;
    repeat (3) wpulse();
    dc = 0;
    cc = 0;
    for (j = 0; j < v; j++) begin
      dc += dis;
      cc += chg;
      @(negedge clk);
    end
    check(dc, ed);
    check(cc, ec);
  endtask : meas
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_power_up;
    @(negedge clk);
    check({sreset, chg, start, dis, cwr}, 16'h0000);
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    check({sreset, start}, 16'h0002);
    @(negedge clk);
    check({sreset, chg, start}, 16'h0002);
    for (j = 0; j < 100 && start !== 1'b1; j++) @(negedge clk);
    check(j >= CW - 2 && j <= CW + 1, 1'b1);
    check({comm, chg}, 16'h0002);
    for (j = 0; j < PT + 9 && sreset !== 1'b1; j++) @(negedge clk);
    check(j >= PT - 2 && j <= PT + 2, 1'b1);
    repeat (2) @(negedge clk);
    check({chg, start}, 16'h0002);
  endtask : t_power_up
  task automatic t_actuator;
    for (j = 0; j < 64; j++) do_tick(1'b1, 16'h0040, 1'b0, 1'b0);
    do_tick(1'b1, 16'hFC00, 1'b0, 1'b0);
    do_tick(1'b0, 16'h0000, 1'b1, 1'b0);
    do_tick(1'b1, 16'hFF80, 1'b0, 1'b0);
    put_gray(15'h0005, 1'b0);
    do_tick(1'b1, 16'hFF80, 1'b0, 1'b0);
    // slow phase only stops on a frame decoded just before the tick
    @(posedge clk);
    gv   <= 1'b1;
    gcyl <= 15'h0000;
    gidx <= 1'b1;
    do_tick(1'b1, 16'hFF80, 1'b0, 1'b0);
    check({cidx, cyl}, 16'h8000);
    check(trk, 1'b1);
    do_tick(1'b1, 16'h0000, 1'b0, 1'b0);
    @(posedge clk);
    ba <= 16'sh0110;
    do_tick(1'b0, 16'h0000, 1'b0, 1'b0);
    check(cur[15], 1'b1);
    @(posedge clk);
    ba <= 16'sh0100;
    tgt <= 15'h000A;
    do_tick(1'b0, 16'h0000, 1'b0, 1'b1);
    check({busy, trk}, 16'h0001);
    put_gray(15'h2AAA, 1'b1);
    put_gray(15'h7FFF, 1'b0);
    put_gray(15'h0000, 1'b0);
  endtask : t_actuator
  task automatic t_spindle;
    @(posedge clk);
    ivl <= 16'd200;
    // a restart aligns the pulse train with the next start phase
    for (j = 0; j < 300 && sreset !== 1'b1; j++) @(negedge clk);
    if (sreset !== 1'b1) tmo();
    for (j = 0; j < 300 && start !== 1'b1; j++) @(negedge clk);
    if (start !== 1'b1) tmo();
    for (j = 0; j < 300 && start !== 1'b0; j++) @(negedge clk);
    if (start !== 1'b0) tmo();
    check(j < PT - 9, 1'b1);
    @(negedge clk);
    check({sreset, start, comm, chg}, 16'h0001);
    check(comm, 1'b0);
    repeat (700) @(negedge clk);
    check(stable, 1'b0);
    @(posedge clk);
    ivl <= 16'd100;
    for (j = 0; j < 500 && stable !== 1'b1; j++) @(negedge clk);
    check(stable, 1'b1);
    meas(16'd100, 0, 0);
    meas(16'd90, 60, 0);
    meas(16'd110, 0, 60);
    meas(16'd100, 0, 0);
  endtask : t_spindle
  task automatic t_seek;
    do_tick(1'b1, 16'hFFFE, 1'b0, 1'b1);
    check({busy, trk}, 16'h0002);
    do_tick(1'b1, 16'h0028, 1'b0, 1'b0);
    put_gray(15'h000A, 1'b0);
    do_tick(1'b0, 16'h0000, 1'b0, 1'b0);
    check({busy, trk}, 16'h0001);
  endtask : t_seek
  initial begin
    {rst, tick, mark, gv, gidx, sreq} = 6'h20;
    gcyl = 15'h0;
    tgt = 15'h0;
    ba = 16'sh0100;
    bb = 16'sh0100;
    ivl = 16'h0;
    repeat (6) @(posedge clk);
    t_power_up();
    t_actuator();
    t_spindle();
    t_seek();
    give_verdict();
  end
endmodule : smc_motor_ctrl_tb
